// ==== rx_crc_pkg.sv ====
// package for the receive crc / parity checker: register map, fields, presets
// assumes a plain register port with one-cycle read latency
package rx_crc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] CFG_ADDR = 8'h12;
  localparam logic [7:0] STATUS_ADDR = 8'h13;

  // ==========================================================================
  // field positions of the configuration register
  localparam int PRESET_VAL_LSB = 16;
  localparam int PARITY_ODD_BIT = 11;
  localparam int PARITY_EN_BIT = 10;
  localparam int KEEP_CLASH_BIT = 9;
  localparam int ALIGN_LSB = 6;
  localparam int PRESET_SEL_LSB = 3;
  localparam int CRC5_BIT = 2;
  localparam int INV_BIT = 1;
  localparam int CRC_EN_BIT = 0;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // ==========================================================================
  // crc presets and residues
  localparam logic [2:0] SEL_ZERO = 3'h0;
  localparam logic [2:0] SEL_A = 3'h1;
  localparam logic [2:0] SEL_A671 = 3'h2;
  localparam logic [2:0] SEL_B = 3'h3;
  localparam logic [2:0] SEL_0012 = 3'h4;
  localparam logic [2:0] SEL_E012 = 3'h5;
  localparam logic [2:0] SEL_ARB = 3'h7;
  localparam logic [15:0] PRE_ZERO = 16'h0000;
  localparam logic [15:0] PRE_A = 16'h6363;
  localparam logic [15:0] PRE_A671 = 16'ha671;
  localparam logic [15:0] PRE_B = 16'hffff;
  localparam logic [15:0] PRE_0012 = 16'h0012;
  localparam logic [15:0] PRE_E012 = 16'he012;
  localparam logic [15:0] RESIDUE_INV = 16'hf0b8;
  localparam logic [15:0] POLY16 = 16'h8408;
  localparam logic [4:0] POLY5 = 5'h14;

  // ==========================================================================
  // mode detector verdicts
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_A,
    MODE_B,
    MODE_JIS
  } detect_mode_t;

endpackage : rx_crc_pkg

// ==== crc_engine.sv ====
// reflected crc shift register, 16-bit or 5-bit polynomial
// assumes bits arrive lsb first, one per i_bit_vld cycle
`timescale 1ns/100ps
module crc_engine (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [15:0] i_preset,
  input wire logic i_crc5,
  input wire logic i_bit_vld,
  input wire logic i_bit,
  output logic [15:0] o_crc
);
  logic fb;

  always_comb
  begin
    fb = o_crc[0] ^ i_bit;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_crc <= 16'h0000;
    else if (i_load)
      o_crc <= i_preset;
    else if (i_bit_vld)
    begin
      if (i_crc5)
        o_crc <= {11'h0, ({1'b0, o_crc[4:1]} ^ (fb ? rx_crc_pkg::POLY5 : 5'h00))};
      else
        o_crc <= {1'b0, o_crc[15:1]} ^ (fb ? rx_crc_pkg::POLY16 : 16'h0000);
    end
  end
endmodule : crc_engine

// ==== byte_assembler.sv ====
// packs data bits into bytes starting at a programmable bit position
// assumes i_start precedes the first bit of a frame
`timescale 1ns/100ps
module byte_assembler (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [2:0] i_align,
  input wire logic i_bit_vld,
  input wire logic i_bit,
  output logic [7:0] o_byte,
  output logic o_byte_vld
);
  logic [2:0] pos_q;
  logic [7:0] acc_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      pos_q <= 3'h0;
      acc_q <= 8'h00;
      o_byte <= 8'h00;
      o_byte_vld <= 1'b0;
    end
    else
    begin
      o_byte_vld <= 1'b0;
      if (i_start)
      begin
        pos_q <= i_align;
        acc_q <= 8'h00;
      end
      else if (i_bit_vld)
      begin
        acc_q[pos_q] <= i_bit;
        pos_q <= pos_q + 3'h1;
        if (pos_q == 3'h7)
        begin
          o_byte <= {i_bit, acc_q[6:0]};
          o_byte_vld <= 1'b1;
          acc_q <= 8'h00;
        end
      end
    end
  end
endmodule : byte_assembler

// ==== rx_crc_parity_checker.sv ====
// receive crc and parity checker with its configuration register
// assumes a decoder delivering one bit per i_bit_vld pulse, same clock
`timescale 1ns/100ps
module rx_crc_parity_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_det_vld,
  input wire rx_crc_pkg::detect_mode_t i_det_mode,
  input wire logic i_det_fast,
  input wire logic i_rx_start,
  input wire logic i_rx_end,
  input wire logic i_bit_vld,
  input wire logic i_bit,
  input wire logic i_collision,
  input wire logic i_parity_eof,
  output logic [7:0] o_byte,
  output logic o_byte_vld,
  output logic o_integrity_err,
  output logic o_crc_ok,
  output logic o_crc_done
);

  // ==========================================================================
  // configuration register
  logic [15:0] preset_val_q;
  logic parity_odd_q;
  logic parity_en_q;
  logic keep_post_clash_bits_q;
  logic [2:0] align_q;
  logic [2:0] preset_sel_q;
  logic crc5_q;
  logic checksum_inverted_compare_q;
  logic crc_en_q;
  logic [3:0] reserved_bits;
  logic [31:0] cfg_word;
  logic cfg_wr;

  assign reserved_bits = 4'h0;
  assign cfg_wr = i_wr && (i_addr == rx_crc_pkg::CFG_ADDR);

  // software write wins the same cycle as a detector verdict: it is the later intent
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      preset_val_q <= rx_crc_pkg::CFG_RESET[31:16];
      parity_odd_q <= 1'b0;
      parity_en_q <= 1'b0;
      keep_post_clash_bits_q <= 1'b0;
      align_q <= 3'h0;
      preset_sel_q <= rx_crc_pkg::SEL_ZERO;
      crc5_q <= 1'b0;
      checksum_inverted_compare_q <= 1'b0;
      crc_en_q <= 1'b0;
    end
    else if (cfg_wr)
    begin
      preset_val_q <= i_wdata[rx_crc_pkg::PRESET_VAL_LSB +: 16];
      parity_odd_q <= i_wdata[rx_crc_pkg::PARITY_ODD_BIT];
      parity_en_q <= i_wdata[rx_crc_pkg::PARITY_EN_BIT];
      keep_post_clash_bits_q <= i_wdata[rx_crc_pkg::KEEP_CLASH_BIT];
      align_q <= i_wdata[rx_crc_pkg::ALIGN_LSB +: 3];
      preset_sel_q <= i_wdata[rx_crc_pkg::PRESET_SEL_LSB +: 3];
      crc5_q <= i_wdata[rx_crc_pkg::CRC5_BIT];
      checksum_inverted_compare_q <= i_wdata[rx_crc_pkg::INV_BIT];
      crc_en_q <= i_wdata[rx_crc_pkg::CRC_EN_BIT];
    end
    else if (i_det_vld)
    begin
      case (i_det_mode)
        rx_crc_pkg::MODE_A:
        begin
          parity_odd_q <= 1'b1;
          parity_en_q <= 1'b1;
          preset_sel_q <= rx_crc_pkg::SEL_A;
          checksum_inverted_compare_q <= 1'b0;
        end
        rx_crc_pkg::MODE_B:
        begin
          preset_sel_q <= rx_crc_pkg::SEL_B;
          checksum_inverted_compare_q <= 1'b1;
          crc_en_q <= 1'b1;
        end
        rx_crc_pkg::MODE_JIS:
        begin
          preset_sel_q <= rx_crc_pkg::SEL_ZERO;
          checksum_inverted_compare_q <= 1'b0;
          if (i_det_fast)
            crc_en_q <= 1'b1;
        end
        default:
        begin
          crc_en_q <= crc_en_q;
        end
      endcase
    end
  end

  always_comb
  begin
    cfg_word = {preset_val_q, reserved_bits, parity_odd_q, parity_en_q,
                keep_post_clash_bits_q, align_q, preset_sel_q, crc5_q,
                checksum_inverted_compare_q, crc_en_q};
  end

  // ==========================================================================
  // register read port
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd && i_addr == rx_crc_pkg::CFG_ADDR)
      o_rdata <= cfg_word;
    else if (i_rd && i_addr == rx_crc_pkg::STATUS_ADDR)
      o_rdata <= {29'h0, o_crc_done, o_crc_ok, o_integrity_err};
    else
      o_rdata <= 32'h0000_0000;
  end

  // ==========================================================================
  // crc preset selection
  logic [15:0] preset_full;
  logic [15:0] preset_eff;

  always_comb
  begin
    case (preset_sel_q)
      rx_crc_pkg::SEL_ZERO: preset_full = rx_crc_pkg::PRE_ZERO;
      rx_crc_pkg::SEL_A: preset_full = rx_crc_pkg::PRE_A;
      rx_crc_pkg::SEL_A671: preset_full = rx_crc_pkg::PRE_A671;
      rx_crc_pkg::SEL_B: preset_full = rx_crc_pkg::PRE_B;
      rx_crc_pkg::SEL_0012: preset_full = rx_crc_pkg::PRE_0012;
      rx_crc_pkg::SEL_E012: preset_full = rx_crc_pkg::PRE_E012;
      rx_crc_pkg::SEL_ARB: preset_full = preset_val_q;
      default: preset_full = rx_crc_pkg::PRE_ZERO;
    endcase
    // 5-bit crc only keeps the low byte of the preset
    preset_eff = crc5_q ? {8'h00, preset_full[7:0]} : preset_full;
  end

  // ==========================================================================
  // bit stream: collision masking and parity extraction
  logic clash_seen_q;
  logic [2:0] bit_cnt_q;
  logic expect_par_q;
  logic run_par_q;
  logic data_bit;
  logic data_vld;
  logic par_vld;
  logic par_bad;

  always_comb
  begin
    // after a collision bits read zero unless they are to be kept
    data_bit = i_bit & (keep_post_clash_bits_q | ~(clash_seen_q | i_collision));
    par_vld = i_bit_vld && parity_en_q && expect_par_q;
    data_vld = i_bit_vld && !par_vld;
    // odd parity: data bits plus parity bit hold an odd number of ones
    par_bad = par_vld && ((run_par_q ^ i_bit) != parity_odd_q);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || i_rx_start)
      clash_seen_q <= 1'b0;
    else if (i_bit_vld && i_collision)
      clash_seen_q <= 1'b1;
  end

  // parity tracks whole bytes from the first received bit, independent of alignment
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || i_rx_start)
    begin
      bit_cnt_q <= 3'h0;
      expect_par_q <= 1'b0;
      run_par_q <= 1'b0;
    end
    else if (par_vld)
    begin
      expect_par_q <= 1'b0;
      run_par_q <= 1'b0;
    end
    else if (data_vld)
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      run_par_q <= run_par_q ^ data_bit;
      expect_par_q <= (bit_cnt_q == 3'h7);
    end
  end

  byte_assembler u_bytes (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_start(i_rx_start),
    .i_align(align_q),
    .i_bit_vld(data_vld),
    .i_bit(data_bit),
    .o_byte(o_byte),
    .o_byte_vld(o_byte_vld)
  );

  // ==========================================================================
  // crc check
  logic [15:0] crc_val;
  logic [15:0] residue;
  logic crc_good;

  crc_engine u_crc (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_load(i_rx_start),
    .i_preset(preset_eff),
    .i_crc5(crc5_q),
    .i_bit_vld(data_vld),
    .i_bit(data_bit),
    .o_crc(crc_val)
  );

  always_comb
  begin
    residue = checksum_inverted_compare_q ? rx_crc_pkg::RESIDUE_INV : 16'h0000;
    if (crc5_q)
      crc_good = (crc_val[4:0] == 5'h00);
    else
      crc_good = (crc_val == residue);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || i_rx_start)
    begin
      o_crc_ok <= 1'b0;
      o_crc_done <= 1'b0;
    end
    else if (i_rx_end && crc_en_q)
    begin
      o_crc_ok <= crc_good;
      o_crc_done <= 1'b1;
    end
  end

  // ==========================================================================
  // data integrity error flag
  // a reception start clears it; an error in that same cycle wins and sets it
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_integrity_err <= 1'b0;
    else if (par_bad && !i_parity_eof)
      o_integrity_err <= 1'b1;
    else if (i_rx_end && crc_en_q && !crc_good)
      o_integrity_err <= 1'b1;
    else if (i_rx_start)
      o_integrity_err <= 1'b0;
  end

endmodule : rx_crc_parity_checker

// ==== rx_crc_parity_checker_monitor.sv ====
// checker for the receive crc / parity block, bound to its top module
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module rx_crc_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_rx_start,
  input wire logic i_rx_end,
  input wire logic i_bit_vld,
  input wire logic i_parity_eof,
  input wire logic o_byte_vld,
  input wire logic o_integrity_err,
  input wire logic o_crc_ok,
  input wire logic o_crc_done
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) != rx_crc_pkg::CFG_ADDR
    && $past(i_addr) != rx_crc_pkg::STATUS_ADDR |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property ($past(i_rd) && $past(i_addr) == rx_crc_pkg::CFG_ADDR
    |-> o_rdata[15:12] == 4'h0)
    else $error("reserved bits not zero");
  byte_cause_a: assert property (o_byte_vld |-> $past(i_bit_vld) ##1 !o_byte_vld)
    else $error("byte strobe without a bit");
  err_cause_a: assert property ($rose(o_integrity_err)
    |-> $past(i_bit_vld) || $past(i_rx_end))
    else $error("integrity error without cause");
  eof_quiet_a: assert property ($rose(o_integrity_err) && $past(i_parity_eof)
    |-> $past(i_rx_end))
    else $error("parity error flagged under end criterion");
  err_clear_a: assert property ($past(i_rx_start) && !$past(i_bit_vld)
    && !$past(i_rx_end) |-> !o_integrity_err)
    else $error("integrity error not cleared at start");
  done_cause_a: assert property ($rose(o_crc_done) |-> $past(i_rx_end))
    else $error("crc done without frame end");
  ok_cause_a: assert property ($rose(o_crc_ok) |-> $past(i_rx_end) && o_crc_done)
    else $error("crc ok outside evaluation");
endmodule : rx_crc_monitor

bind rx_crc_parity_checker rx_crc_monitor i_mon (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_start(i_rx_start),
  .i_rx_end(i_rx_end), .i_bit_vld(i_bit_vld), .i_parity_eof(i_parity_eof),
  .o_byte_vld(o_byte_vld), .o_integrity_err(o_integrity_err), .o_crc_ok(o_crc_ok),
  .o_crc_done(o_crc_done));

// ==== rx_crc_partner.sv ====
// remote transmitter model: frame strobes and one bit every two cycles
// assumes the caller orders start, bits and end on the shared clock
`timescale 1ns/100ps
module rx_crc_partner (
  input wire logic i_ref_clk,
  output logic o_rx_start,
  output logic o_rx_end,
  output logic o_bit_vld,
  output logic o_bit,
  output logic o_collision
);
  initial
  begin
    o_rx_start = 1'b0;
    o_rx_end = 1'b0;
    o_bit_vld = 1'b0;
    o_bit = 1'b0;
    o_collision = 1'b0;
  end

  task automatic frame_start();
    @(posedge i_ref_clk);
    o_rx_start <= 1'b1;
    @(posedge i_ref_clk);
    o_rx_start <= 1'b0;
  endtask : frame_start

  task automatic frame_end();
    @(posedge i_ref_clk);
    o_rx_end <= 1'b1;
    @(posedge i_ref_clk);
    o_rx_end <= 1'b0;
  endtask : frame_end

  // line shows the inverse once released, so a stale value never passes
  task automatic send_bit(input logic b, input logic c);
    @(posedge i_ref_clk);
    o_bit_vld <= 1'b1;
    o_bit <= b;
    o_collision <= c;
    @(posedge i_ref_clk);
    o_bit_vld <= 1'b0;
    o_bit <= ~b;
    o_collision <= 1'b0;
  endtask : send_bit

  task automatic send_bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) send_bit(v[i], 1'b0);
  endtask : send_bits
endmodule : rx_crc_partner

// ==== rx_crc_parity_checker_tb.sv ====
// self-checking bench for the receive crc / parity block
// assumes the partner model drives the bit stream and frame strobes
`timescale 1ns/100ps
module rx_crc_parity_checker_tb;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_det_vld = 1'b0;
  rx_crc_pkg::detect_mode_t i_det_mode = rx_crc_pkg::MODE_NONE;
  logic i_det_fast = 1'b0;
  logic i_parity_eof = 1'b0;
  logic rx_start, rx_end, bit_vld, rx_bit, coll;
  logic [31:0] o_rdata;
  logic [7:0] o_byte;
  logic o_byte_vld, o_integrity_err, o_crc_ok, o_crc_done;
  logic [7:0] got_byte = 8'h0;
  logic [15:0] pre [8] = '{16'h0, 16'h6363, 16'ha671, 16'hffff, 16'h0012, 16'he012, 16'h0,
    16'h5a3c};
  int n_bytes = 0;
  int b0;
  int bad_count = 0;
  int n_compared = 0;

  always #10 i_ref_clk = ~i_ref_clk;

  rx_crc_parity_checker i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_det_vld(i_det_vld),
    .i_det_mode(i_det_mode), .i_det_fast(i_det_fast), .i_rx_start(rx_start),
    .i_rx_end(rx_end), .i_bit_vld(bit_vld), .i_bit(rx_bit), .i_collision(coll),
    .i_parity_eof(i_parity_eof), .o_byte(o_byte), .o_byte_vld(o_byte_vld),
    .o_integrity_err(o_integrity_err), .o_crc_ok(o_crc_ok), .o_crc_done(o_crc_done));
  rx_crc_partner i_peer (.i_ref_clk(i_ref_clk), .o_rx_start(rx_start), .o_rx_end(rx_end),
    .o_bit_vld(bit_vld), .o_bit(rx_bit), .o_collision(coll));

  always @(posedge i_ref_clk) if (o_byte_vld === 1'b1)
  begin
    got_byte <= o_byte;
    n_bytes <= n_bytes + 1;
  end

  // ==========================================================================
  // access and compare tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 cmp("rdata", e, o_rdata & m);
  endtask : rd

  task automatic det(input rx_crc_pkg::detect_mode_t md, input logic f);
    @(posedge i_ref_clk);
    i_det_vld <= 1'b1;
    i_det_mode <= md;
    i_det_fast <= f;
    @(posedge i_ref_clk);
    i_det_vld <= 1'b0;
  endtask : det

  task automatic settle();
    @(posedge i_ref_clk);
    #1;
  endtask : settle

  // empty or short frames keep the expected crc outcome obvious
  task automatic run_crc(input logic [31:0] c, input logic [15:0] v, input int n,
    input logic ok, input logic dn);
    wr(rx_crc_pkg::CFG_ADDR, c);
    i_peer.frame_start();
    i_peer.send_bits(v, n);
    i_peer.frame_end();
    #1 cmp("crc_ok", {31'h0, ok}, {31'h0, o_crc_ok});
    cmp("crc_done", {31'h0, dn}, {31'h0, o_crc_done});
    cmp("err", {31'h0, dn & ~ok}, {31'h0, o_integrity_err});
  endtask : run_crc

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    wrap_up();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(rx_crc_pkg::CFG_ADDR, rx_crc_pkg::CFG_RESET, 32'hffffffff);
    wr(rx_crc_pkg::CFG_ADDR, 32'hffffffff);
    rd(rx_crc_pkg::CFG_ADDR, 32'hffff0fff, 32'hffffffff);
    rd(8'h20, 32'h0, 32'hffffffff);
    // feeding the preset itself lsb first drives a reflected crc to zero
    for (int s = 0; s < 8; s++)
      run_crc(32'h5a3c0001 | (s << 3), pre[s], 16, 1'b1, 1'b1);
    rd(rx_crc_pkg::STATUS_ADDR, 32'h6, 32'h7);
    run_crc(32'h5a3c0001 | (3 << 3), 16'h5a3c, 16, 1'b0, 1'b1);
    run_crc(32'hff13003d, 16'h0013, 5, 1'b1, 1'b1);
    run_crc(32'hff000039, 16'h0, 0, 1'b0, 1'b1);
    run_crc(32'hf0b8003b, 16'h0, 0, 1'b1, 1'b1);
    run_crc(32'hf0b80039, 16'h0, 0, 1'b0, 1'b1);
    run_crc(32'h5a3c0038, 16'h0, 0, 1'b0, 1'b0);
    wr(rx_crc_pkg::CFG_ADDR, 32'h400);
    i_peer.frame_start();
    b0 = n_bytes;
    i_peer.send_bits(16'h01, 8);
    i_peer.send_bit(1'b1, 1'b0);
    settle();
    cmp("err", 32'h0, {31'h0, o_integrity_err});
    i_peer.send_bits(16'h03, 8);
    i_peer.send_bit(1'b1, 1'b0);
    // a byte after the bad parity proves reception carried on
    i_peer.send_bits(16'h05, 8);
    i_peer.send_bit(1'b0, 1'b0);
    i_peer.frame_end();
    #1 cmp("err", 32'h1, {31'h0, o_integrity_err});
    cmp("bytes", 32'h3, n_bytes - b0);
    cmp("byte", 32'h5, {24'h0, got_byte});
    wr(rx_crc_pkg::CFG_ADDR, 32'hc00);
    i_peer.frame_start();
    #1 cmp("err", 32'h0, {31'h0, o_integrity_err});
    i_peer.send_bits(16'h01, 8);
    i_peer.send_bit(1'b0, 1'b0);
    @(posedge i_ref_clk);
    i_parity_eof <= 1'b1;
    i_peer.send_bits(16'h01, 8);
    i_peer.send_bit(1'b1, 1'b0);
    i_peer.frame_end();
    i_parity_eof <= 1'b0;
    #1 cmp("err", 32'h0, {31'h0, o_integrity_err});
    wr(rx_crc_pkg::CFG_ADDR, 32'hc0);
    i_peer.frame_start();
    b0 = n_bytes;
    i_peer.send_bits(16'h15, 5);
    settle();
    cmp("bytes", 32'h1, n_bytes - b0);
    cmp("byte", 32'ha8, {24'h0, got_byte});
    for (int k = 0; k < 2; k++)
    begin
      wr(rx_crc_pkg::CFG_ADDR, k << 9);
      i_peer.frame_start();
      i_peer.send_bits(16'h3, 2);
      i_peer.send_bit(1'b1, 1'b1);
      i_peer.send_bits(16'h1f, 5);
      settle();
      cmp("byte", (k == 1) ? 32'hff : 32'h03, {24'h0, got_byte});
    end
    wr(rx_crc_pkg::CFG_ADDR, 32'h0);
    det(rx_crc_pkg::MODE_A, 1'b0);
    rd(rx_crc_pkg::CFG_ADDR, 32'hc08, 32'hc3a);
    det(rx_crc_pkg::MODE_B, 1'b0);
    rd(rx_crc_pkg::CFG_ADDR, 32'h1b, 32'h3b);
    // crc enable cleared first so the fast verdict has something to set
    wr(rx_crc_pkg::CFG_ADDR, 32'h1a);
    det(rx_crc_pkg::MODE_JIS, 1'b0);
    rd(rx_crc_pkg::CFG_ADDR, 32'h00, 32'h3b);
    det(rx_crc_pkg::MODE_JIS, 1'b1);
    rd(rx_crc_pkg::CFG_ADDR, 32'h01, 32'h3b);
    det(rx_crc_pkg::MODE_NONE, 1'b1);
    rd(rx_crc_pkg::CFG_ADDR, 32'h01, 32'hfff);
    wr(rx_crc_pkg::CFG_ADDR, 32'h0);
    rd(rx_crc_pkg::CFG_ADDR, 32'h0, 32'hffffffff);
    wrap_up();
  end
endmodule : rx_crc_parity_checker_tb
